// ==== ramcfg_pkg.sv ====
package ramcfg_pkg;

  // Address map of the CPU bus
  localparam logic [23:0] IRAM_BASE     = 24'h000000;
  localparam logic [23:0] IRAM_TOP      = 24'h000FFF;
  localparam logic [23:0] PER1_BASE     = 24'h004000;
  localparam logic [23:0] PER1_TOP      = 24'h0043FF;
  localparam logic [23:0] DRAM_BASE     = 24'h004800;
  localparam logic [23:0] DRAM_TOP      = 24'h004FFF;
  localparam logic [23:0] PER2_BASE     = 24'h005000;
  localparam logic [23:0] PER2_TOP      = 24'h005FFF;
  localparam int          DRAM_BYTES    = 384;
  localparam int          IRAM_WORDS    = 2048;

  // Register offsets
  localparam logic [23:0] ADDR_FL_CTRL  = 24'h005320;
  localparam logic [23:0] ADDR_GUARD    = 24'h005324;
  localparam logic [23:0] ADDR_RAMSZ    = 24'h005326;

  // Field positions
  localparam int RSZ_LSB  = 0;
  localparam int ACT_LSB  = 4;
  localparam int DBG_BIT  = 8;
  localparam int FLC_LSB  = 0;
  localparam int WCYC_LSB = 8;
  localparam int REV_BIT  = 12;

  // Values after reset and fixed values
  localparam logic [2:0]  RSZ_RST       = 3'h2;
  localparam logic [2:0]  ACT_SIZE      = 3'h2;
  localparam logic        DBG_RST       = 1'b0;
  localparam logic [2:0]  FLC_RST       = 3'h3;
  localparam logic [1:0]  WCYC_RST      = 2'h3;
  localparam logic        REV_RST       = 1'b0;
  localparam logic [7:0]  GUARD_RST     = 8'h00;
  localparam logic [7:0]  GUARD_KEY     = 8'h96;
  localparam logic [23:0] DBG_BASE_LOW  = 24'h000000;
  localparam logic [23:0] DBG_BASE_HIGH = 24'hFFFC00;

  // Size codes
  localparam logic [2:0]  SZ_512 = 3'h5;
  localparam logic [2:0]  SZ_1K  = 3'h4;
  localparam logic [2:0]  SZ_2K  = 3'h3;
  localparam logic [2:0]  SZ_4K  = 3'h2;

  // Display RAM access length is code plus this many cycles
  localparam logic [2:0]  WAIT_BASE = 3'h2;

  typedef struct packed {
    logic [23:0] addr;
    logic        we;
    logic [1:0]  be;
    logic [15:0] wdata;
  } bus_cmd_t;

  typedef struct packed {
    logic [1:0] wait_code;
    logic       reverse;
  } dram_cfg_t;

  function automatic logic [7:0] mirror8(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7 - i];
    end
    return r;
  endfunction

  // Reserved codes fall back to the full array
  function automatic logic [12:0] ram_limit(input logic [2:0] code);
    case (code)
      SZ_512:  ram_limit = 13'h0200;
      SZ_1K:   ram_limit = 13'h0400;
      SZ_2K:   ram_limit = 13'h0800;
      default: ram_limit = 13'h1000;
    endcase
  endfunction

  function automatic logic in_area(input logic [23:0] a, input logic [23:0] lo,
                                   input logic [23:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

endpackage

// ==== iram_store.sv ====
`timescale 1ns/1ps
module iram_store
  import ramcfg_pkg::*;
#(
  parameter int WORDS = IRAM_WORDS
) (
  input  wire logic        mclk,     // CPU clock
  input  wire logic        en,       // Access strobe
  input  wire logic        we,       // Write
  input  wire logic [1:0]  be,       // Byte lanes
  input  wire logic [10:0] waddr,    // Word address
  input  wire logic [15:0] wdata,    // Write data
  output logic      [15:0] rdata     // Registered read data
);

  logic [15:0] mem [WORDS];

  always_ff @(posedge mclk) begin
    if (en && we) begin
      if (be[0]) begin
        mem[waddr][7:0] <= wdata[7:0];
      end
      if (be[1]) begin
        mem[waddr][15:8] <= wdata[15:8];
      end
    end
  end

  // No reset on the data path; RAM contents are undefined at power-up
  always_ff @(posedge mclk) begin
    if (en && !we) begin
      rdata <= mem[waddr];
    end
  end

endmodule

// ==== dram_ctrl.sv ====
`timescale 1ns/1ps
module dram_ctrl
  import ramcfg_pkg::*;
#(
  parameter int DEPTH = DRAM_BYTES
) (
  input  wire logic        mclk,     // CPU clock
  input  wire logic        rst_b,    // Async reset, active low
  input  wire logic        start,    // Begin one byte access
  input  wire logic        we,       // Write
  input  wire logic [10:0] offset,   // Byte offset in the area
  input  wire logic [7:0]  wbyte,    // CPU byte
  input  wire dram_cfg_t   cfg,      // Wait code and bit reverse
  output logic             done,     // One-cycle end of access
  output logic      [7:0]  rbyte,    // Byte as the CPU sees it
  input  wire logic [8:0]  lcd_addr, // Display read address
  output logic      [7:0]  lcd_data  // Display read data
);

  logic [7:0]  mem [DEPTH];
  logic [2:0]  cnt;
  logic        busy;
  logic        op_we;
  logic        op_rev;
  logic        op_ok;
  logic [8:0]  op_off;
  logic [7:0]  op_byte;
  logic [7:0]  raw_byte;

  // Settings are caught at the start, so a write during an access cannot stretch it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      busy     <= 1'b0;
      cnt      <= 3'h0;
      op_we    <= 1'b0;
      op_rev   <= 1'b0;
      op_ok    <= 1'b0;
      op_off   <= 9'h000;
      op_byte  <= 8'h00;
      raw_byte <= 8'h00;
    end else if (start && !busy) begin
      busy     <= 1'b1;
      // One less than the length: the answer cycle itself is the last cycle
      cnt      <= {1'b0, cfg.wait_code} + WAIT_BASE - 3'h1;
      op_we    <= we;
      op_rev   <= cfg.reverse;
      op_ok    <= (offset < 11'(DEPTH));
      op_off   <= offset[8:0];
      op_byte  <= cfg.reverse ? mirror8(wbyte) : wbyte;
      raw_byte <= wbyte;
    end else if (busy) begin
      cnt <= cnt - 3'h1;
      if (cnt == 3'h1) begin
        busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      done <= 1'b0;
    end else begin
      done <= busy && (cnt == 3'h1);
    end
  end

  // General-purpose use and display use share the array
  always_ff @(posedge mclk) begin
    if (busy && cnt == 3'h1 && op_we && op_ok) begin
      mem[op_off] <= op_byte;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rbyte <= 8'h00;
    end else if (busy && cnt == 3'h1 && !op_we) begin
      if (!op_ok) begin
        rbyte <= 8'h00;
      end else begin
        rbyte <= op_rev ? mirror8(mem[op_off]) : mem[op_off];
      end
    end
  end

  always_ff @(posedge mclk) begin
    lcd_data <= mem[lcd_addr];
  end

  a_rev_store:
    assert property (@(posedge mclk) disable iff (!rst_b)
      (busy && cnt == 3'h1 && op_we && op_ok)
      |=> mem[$past(op_off)] == ($past(op_rev) ? mirror8($past(raw_byte))
                                               : $past(raw_byte)))
    else $error("display byte stored with wrong bit order");

endmodule

// ==== ram_size_and_display_ram_ctrl.sv ====
`timescale 1ns/1ps
// Operation
// - The size code decodes 5 as 512 B, 4 as 1 KB, 3 as 2 KB, 2 as 4 KB and resets to 2.
// - Bits 6 to 4 of the size register always read 2, and writes to them do nothing.
// - Bit 8 puts the debug base at 0x0 when set and at 0xfffc00 when clear, reset 0.
// - Writes to the size register are dropped unless the guard register holds 0x96.
// - Display RAM is 384 bytes inside 0x4800-0x4fff, byte wide, two to five cycles a go.
// - The CPU may use the display RAM as plain memory when the display does not.
// - Wait code 3, 2, 1, 0 gives 5, 4, 3, 2 cycles, and resets to 3.
// - With bit 12 set each display byte is mirrored both ways; reset clears it.
// - Peripheral area one, 1 KB from 0x4000, answers in one cycle.
// - Peripheral area two, 4 KB from 0x5000, answers in one cycle.
// - Internal RAM 0x0-0xfff answers in one cycle, usable only up to the chosen size.
module ram_size_and_display_ram_ctrl
  import ramcfg_pkg::*;
(
  input  wire logic        mclk,            // CPU clock
  input  wire logic        rst_b,           // Async reset, active low
  input  wire logic        bus_req,         // Request, one cycle
  input  wire bus_cmd_t    bus_cmd,         // Address, write, lanes, data
  output logic             bus_ack,         // Answer, one cycle
  output logic      [15:0] bus_rdata,       // Read data
  output logic             bus_fault,       // Unmapped or beyond size
  output logic             per1_sel,        // Peripheral area one strobe
  output logic             per2_sel,        // Peripheral area two strobe
  output bus_cmd_t         per_cmd,         // Command to peripherals
  input  wire logic [15:0] per_rdata,       // Peripheral read data
  input  wire logic [8:0]  lcd_addr,        // Display read address
  output logic      [7:0]  lcd_data,        // Display read data
  output logic      [23:0] debug_base_addr, // Debug base address
  output logic      [12:0] ram_limit_bytes, // Usable internal RAM
  output logic      [2:0]  flash_read_cycles // Flash read setting
);

  typedef enum {SRC_LOCAL, SRC_IRAM, SRC_DRAM} src_t;

  logic [2:0]  ram_size_sel;
  logic        debug_base_sel;
  logic [7:0]  config_write_guard;
  logic [1:0]  display_ram_wait_cycles;
  logic        display_ram_bit_reverse;
  logic        busy;
  src_t        src;
  logic [15:0] rdata_q;
  logic        fast_ack;
  logic        dram_done;
  logic [7:0]  dram_byte;
  logic [15:0] iram_rdata;

  logic        take;
  logic        hit_iram;
  logic        hit_per1;
  logic        hit_dram;
  logic        hit_per2;
  logic        hit_fl;
  logic        hit_guard;
  logic        hit_sz;
  logic        iram_ok;
  logic        unmapped;
  logic [15:0] next_rdata;
  logic [15:0] fl_view;
  logic [15:0] sz_view;

  dram_cfg_t   dcfg;

  // The answer cycle of a display access already takes the next request
  assign take      = bus_req && (!busy || dram_done);
  assign hit_iram  = in_area(bus_cmd.addr, IRAM_BASE, IRAM_TOP);
  assign hit_per1  = in_area(bus_cmd.addr, PER1_BASE, PER1_TOP);
  assign hit_dram  = in_area(bus_cmd.addr, DRAM_BASE, DRAM_TOP);
  assign hit_fl    = bus_cmd.addr[23:1] == ADDR_FL_CTRL[23:1];
  assign hit_guard = bus_cmd.addr[23:1] == ADDR_GUARD[23:1];
  assign hit_sz    = bus_cmd.addr[23:1] == ADDR_RAMSZ[23:1];
  assign hit_per2  = in_area(bus_cmd.addr, PER2_BASE, PER2_TOP)
                     && !hit_fl && !hit_guard && !hit_sz;
  assign iram_ok   = hit_iram && ({1'b0, bus_cmd.addr[11:0]} < ram_limit_bytes);
  assign unmapped  = !(hit_iram || hit_per1 || hit_dram
                       || in_area(bus_cmd.addr, PER2_BASE, PER2_TOP));

  assign per1_sel  = take && hit_per1;
  assign per2_sel  = take && hit_per2;
  assign per_cmd   = bus_cmd;

  assign ram_limit_bytes   = ram_limit(ram_size_sel);
  assign debug_base_addr   = debug_base_sel ? DBG_BASE_LOW : DBG_BASE_HIGH;
  assign dcfg.wait_code    = display_ram_wait_cycles;
  assign dcfg.reverse      = display_ram_bit_reverse;

  assign fl_view = {3'h0, display_ram_bit_reverse, 2'h0, display_ram_wait_cycles,
                    5'h00, flash_read_cycles};
  assign sz_view = {7'h00, debug_base_sel, 1'b0, ACT_SIZE, 1'b0, ram_size_sel};

  // Size register: lanes honoured, guard checked at the write edge
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ram_size_sel   <= RSZ_RST;
      debug_base_sel <= DBG_RST;
    end else if (take && bus_cmd.we && hit_sz && config_write_guard == GUARD_KEY) begin
      if (bus_cmd.be[0]) begin
        ram_size_sel <= bus_cmd.wdata[RSZ_LSB +: 3];
      end
      if (bus_cmd.be[1]) begin
        debug_base_sel <= bus_cmd.wdata[DBG_BIT];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      config_write_guard <= GUARD_RST;
    end else if (take && bus_cmd.we && hit_guard && bus_cmd.be[0]) begin
      config_write_guard <= bus_cmd.wdata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flash_read_cycles       <= FLC_RST;
      display_ram_wait_cycles <= WCYC_RST;
      display_ram_bit_reverse <= REV_RST;
    end else if (take && bus_cmd.we && hit_fl) begin
      if (bus_cmd.be[0]) begin
        flash_read_cycles <= bus_cmd.wdata[FLC_LSB +: 3];
      end
      if (bus_cmd.be[1]) begin
        display_ram_wait_cycles <= bus_cmd.wdata[WCYC_LSB +: 2];
        display_ram_bit_reverse <= bus_cmd.wdata[REV_BIT];
      end
    end
  end

  always_comb begin
    next_rdata = 16'h0000;
    if (hit_fl) begin
      next_rdata = fl_view;
    end else if (hit_guard) begin
      next_rdata = {8'h00, config_write_guard};
    end else if (hit_sz) begin
      next_rdata = sz_view;
    end else if (hit_per1 || hit_per2) begin
      next_rdata = per_rdata;
    end
  end

  // Only display accesses hold the bus; every other area answers after one edge
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
    end else if (take && hit_dram) begin
      busy <= 1'b1;
    end else if (dram_done) begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fast_ack  <= 1'b0;
      bus_fault <= 1'b0;
    end else begin
      fast_ack  <= take && !hit_dram;
      bus_fault <= take && (unmapped || (hit_iram && !iram_ok));
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      src     <= SRC_LOCAL;
      rdata_q <= 16'h0000;
    end else if (take) begin
      rdata_q <= next_rdata;
      if (hit_dram) begin
        src <= SRC_DRAM;
      end else if (iram_ok) begin
        src <= SRC_IRAM;
      end else begin
        src <= SRC_LOCAL;
      end
    end
  end

  assign bus_ack = fast_ack || dram_done;

  // All three sources are flops; only the select is a mux
  always_comb begin
    case (src)
      SRC_IRAM: bus_rdata = iram_rdata;
      SRC_DRAM: bus_rdata = {dram_byte, dram_byte};
      default:  bus_rdata = rdata_q;
    endcase
  end

  iram_store u_iram (
    .mclk  (mclk),
    .en    (take && iram_ok),
    .we    (bus_cmd.we),
    .be    (bus_cmd.be),
    .waddr (bus_cmd.addr[11:1]),
    .wdata (bus_cmd.wdata),
    .rdata (iram_rdata)
  );

  dram_ctrl u_dram (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .start    (take && hit_dram),
    .we       (bus_cmd.we),
    .offset   (bus_cmd.addr[10:0] - DRAM_BASE[10:0]),
    .wbyte    (bus_cmd.addr[0] ? bus_cmd.wdata[15:8] : bus_cmd.wdata[7:0]),
    .cfg      (dcfg),
    .done     (dram_done),
    .rbyte    (dram_byte),
    .lcd_addr (lcd_addr),
    .lcd_data (lcd_data)
  );

  a_size_locked:
    assert property (@(posedge mclk) disable iff (!rst_b)
      (take && bus_cmd.we && hit_sz && config_write_guard != GUARD_KEY)
      |=> $stable(ram_size_sel) && $stable(debug_base_sel))
    else $error("size register changed without the guard key");

  a_size_unlocked:
    assert property (@(posedge mclk) disable iff (!rst_b)
      (take && bus_cmd.we && hit_sz && bus_cmd.be[0] && config_write_guard == GUARD_KEY)
      |=> ram_size_sel == $past(bus_cmd.wdata[2:0]))
    else $error("keyed size write not taken");

  a_actual_size:
    assert property (@(posedge mclk) disable iff (!rst_b)
      (take && !bus_cmd.we && hit_sz) |=> bus_ack && bus_rdata[6:4] == 3'h2)
    else $error("actual size field not reading 2");

  a_debug_base:
    assert property (@(posedge mclk) disable iff (!rst_b)
      $fell(debug_base_sel) |-> debug_base_addr == 24'hFFFC00)
    else $error("debug base not at high address");

  a_fast_answer:
    assert property (@(posedge mclk) disable iff (!rst_b)
      (take && (hit_per1 || hit_per2 || hit_iram)) |=> bus_ack && !busy)
    else $error("one-cycle area did not answer after one edge");

  a_dram_short:
    assert property (@(posedge mclk) disable iff (!rst_b)
      (take && hit_dram && display_ram_wait_cycles == 2'h0) |=> !bus_ack ##1 bus_ack)
    else $error("two-cycle display access wrong length");

  a_dram_long:
    assert property (@(posedge mclk) disable iff (!rst_b)
      (take && hit_dram && display_ram_wait_cycles == 2'h3) |=> !bus_ack[*4] ##1 bus_ack)
    else $error("five-cycle display access wrong length");

  a_range_fault:
    assert property (@(posedge mclk) disable iff (!rst_b)
      (take && hit_iram && bus_cmd.addr[11:0] >= 12'h200 && ram_size_sel == 3'h5)
      |=> bus_fault && bus_ack)
    else $error("access beyond 512 byte limit not flagged");

  a_per_strobe:
    assert property (@(posedge mclk) disable iff (!rst_b)
      per2_sel |-> !hit_fl && !hit_guard && !hit_sz && (!busy || dram_done))
    else $error("peripheral strobe on a local register");

  a_dram_three:
    assert property (@(posedge mclk) disable iff (!rst_b)
      (take && hit_dram && display_ram_wait_cycles == 2'h1) |=> !bus_ack[*2] ##1 bus_ack)
    else $error("three-cycle display access wrong length");

  a_dram_four:
    assert property (@(posedge mclk) disable iff (!rst_b)
      (take && hit_dram && display_ram_wait_cycles == 2'h2) |=> !bus_ack[*3] ##1 bus_ack)
    else $error("four-cycle display access wrong length");

  a_dram_holds:
    assert property (@(posedge mclk) disable iff (!rst_b)
      (take && hit_dram) |=> busy && !bus_ack && !bus_fault)
    else $error("display access did not hold the bus");

  a_mapped_no_fault:
    assert property (@(posedge mclk) disable iff (!rst_b)
      (take && (hit_per1 || hit_per2 || hit_fl || hit_guard || hit_sz))
      |=> bus_ack && !bus_fault)
    else $error("mapped register access flagged as fault");

  a_debug_low:
    assert property (@(posedge mclk) disable iff (!rst_b)
      debug_base_sel |-> debug_base_addr == 24'h000000)
    else $error("debug base not at address zero");

  a_size_reserved:
    assert property (@(posedge mclk) disable iff (!rst_b)
      (take && !bus_cmd.we && hit_sz)
      |=> bus_rdata[15:9] == 7'h00 && !bus_rdata[7] && !bus_rdata[3])
    else $error("reserved size register bits not zero");

  a_limit_small:
    assert property (@(posedge mclk) disable iff (!rst_b)
      ram_size_sel == 3'h5 |-> ram_limit_bytes == 13'h0200)
    else $error("code 5 not decoded as 512 bytes");

  a_limit_full:
    assert property (@(posedge mclk) disable iff (!rst_b)
      ram_size_sel == 3'h2 |-> ram_limit_bytes == 13'h1000)
    else $error("code 2 not decoded as 4 KB");

  a_guard_read:
    assert property (@(posedge mclk) disable iff (!rst_b)
      (take && !bus_cmd.we && hit_guard) |=> bus_ack && bus_rdata == {8'h00, config_write_guard})
    else $error("guard register read back wrong");

endmodule

// ==== cpu_master.sv ====
`timescale 1ns/1ps
module cpu_master
  import ramcfg_pkg::*;
(
  input  wire logic        mclk,      // CPU clock
  output logic             bus_req,   // Request pulse
  output bus_cmd_t         bus_cmd,   // Address, write, lanes, data
  input  wire logic        bus_ack,   // Answer
  input  wire logic [15:0] bus_rdata, // Read data
  input  wire logic        bus_fault  // Fault flag
);
  logic [15:0] rd;
  logic        flt;
  logic        hung;
  int          cyc;

  initial begin
    bus_req = 1'b0;
    bus_cmd = '0;
    hung    = 1'b0;
  end

  // One request per call; the answer is looked at mid-cycle to stay off the flop edge
  task automatic xfer(input logic [23:0] a, input logic w, input logic [1:0] lanes,
                      input logic [15:0] d);
    @(negedge mclk);
    bus_cmd = '{a, w, lanes, d};
    bus_req = 1'b1;
    // Stays set if no answer comes, so the run is reported instead of hanging
    hung    = 1'b1;
    cyc     = 0;
    @(posedge mclk);
    while (cyc < 20) begin
      @(negedge mclk);
      bus_req = 1'b0;
      cyc++;
      if (bus_ack === 1'b1) begin
        hung = 1'b0;
        rd  = bus_rdata;
        flt = bus_fault;
        break;
      end
    end
  endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
  import ramcfg_pkg::*;
  logic        mclk;
  logic        rst_b;
  logic        bus_req;
  bus_cmd_t    bus_cmd;
  logic        bus_ack;
  logic [15:0] bus_rdata;
  logic        bus_fault;
  logic        per1_sel;
  logic        per2_sel;
  bus_cmd_t    per_cmd;
  logic [15:0] per_rdata;
  logic [15:0] idle_pat = 16'hC3A5;
  logic [8:0]  lcd_addr;
  logic [7:0]  lcd_data;
  logic [23:0] debug_base_addr;
  logic [12:0] ram_limit_bytes;
  logic [2:0]  flash_read_cycles;
  int          n_errors;
  int          compares;
  logic [2:0]  sz_code [4] = '{3'h2, 3'h3, 3'h4, 3'h5};
  logic [23:0] sz_lim [4]  = '{24'h1000, 24'h0800, 24'h0400, 24'h0200};

  initial begin
    mclk = 1'b0;
    // Frequency ceilings of the display settings do not show in a cycle model
    forever #25 mclk = ~mclk;
  end

  // Unselected peripherals leave the lines wandering, never a stale value
  always @(posedge mclk) idle_pat <= ~idle_pat;
  assign per_rdata = (per1_sel | per2_sel) ? (per_cmd.addr[15:0] ^ 16'h5A5A) : idle_pat;

  cpu_master m (.mclk(mclk), .bus_req(bus_req), .bus_cmd(bus_cmd), .bus_ack(bus_ack),
                .bus_rdata(bus_rdata), .bus_fault(bus_fault));

  ram_size_and_display_ram_ctrl dut (
    .mclk(mclk), .rst_b(rst_b), .bus_req(bus_req), .bus_cmd(bus_cmd), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata), .bus_fault(bus_fault), .per1_sel(per1_sel), .per2_sel(per2_sel),
    .per_cmd(per_cmd), .per_rdata(per_rdata), .lcd_addr(lcd_addr), .lcd_data(lcd_data),
    .debug_base_addr(debug_base_addr), .ram_limit_bytes(ram_limit_bytes),
    .flash_read_cycles(flash_read_cycles));

  task automatic close_out();
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [23:0] a, input logic [1:0] lanes, input logic [15:0] d,
                    input int n);
    m.xfer(a, 1'b1, lanes, d);
    if (m.hung) begin
      n_errors++;
      close_out();
    end
    chk(24'(m.cyc), 24'(n));
  endtask

  task automatic rd(input logic [23:0] a, input logic [15:0] e, input int n);
    m.xfer(a, 1'b0, 2'h3, 16'h0000);
    if (m.hung) begin
      n_errors++;
      close_out();
    end
    chk(24'(m.rd), 24'(e));
    chk(24'(m.cyc), 24'(n));
  endtask

  // Guard is opened only around the size write and shut again at once
  task automatic key_wr(input logic [15:0] d);
    wr(ADDR_GUARD, 2'h1, 16'h0096, 1);
    wr(ADDR_RAMSZ, 2'h3, d, 1);
    wr(ADDR_GUARD, 2'h1, 16'h0000, 1);
  endtask

  initial begin
    rst_b    = 1'b0;
    lcd_addr = 9'h000;
    n_errors = 0;
    compares = 0;
    repeat (20) @(negedge mclk);
    rst_b = 1'b1;
    chk(debug_base_addr, DBG_BASE_HIGH);
    chk(24'(ram_limit_bytes), 24'h001000);
    rd(ADDR_FL_CTRL, 16'h0303, 1);
    rd(ADDR_RAMSZ, 16'h0022, 1);
    wr(ADDR_RAMSZ, 2'h3, 16'h0105, 1);
    rd(ADDR_RAMSZ, 16'h0022, 1);
    key_wr(16'h0175);
    rd(ADDR_GUARD, 16'h0000, 1);
    rd(ADDR_RAMSZ, 16'h0125, 1);
    chk(debug_base_addr, DBG_BASE_LOW);
    chk(24'(ram_limit_bytes), 24'h000200);
    for (int i = 0; i < 4; i++) begin
      key_wr({13'h0000, sz_code[i]});
      chk(24'(ram_limit_bytes), sz_lim[i]);
    end
    wr(24'h0001FE, 2'h3, 16'hBEEF, 1);
    rd(24'h0001FE, 16'hBEEF, 1);
    wr(24'h000200, 2'h3, 16'h1234, 1);
    chk(24'(m.flt), 24'h000001);
    rd(24'h000200, 16'h0000, 1);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_FL_CTRL, 2'h3, {6'h00, 2'(c), 8'h03}, 1);
      wr(DRAM_BASE + 24'(2 * c), 2'h3, {2{8'h30 + 8'(c)}}, c + 2);
      rd(DRAM_BASE + 24'(2 * c), {2{8'h30 + 8'(c)}}, c + 2);
    end
    chk(24'(flash_read_cycles), 24'h000003);
    wr(ADDR_FL_CTRL, 2'h3, 16'h1003, 1);
    rd(ADDR_FL_CTRL, 16'h1003, 1);
    wr(24'h004801, 2'h2, 16'h0100, 2);
    rd(24'h004801, 16'h0101, 2);
    lcd_addr = 9'h001;
    @(negedge mclk);
    @(negedge mclk);
    chk(24'(lcd_data), 24'h000080);
    wr(ADDR_FL_CTRL, 2'h3, 16'h0003, 1);
    rd(24'h004801, 16'h8080, 2);
    rd(24'h004980, 16'h0000, 2);
    rd(PER1_BASE, PER1_BASE[15:0] ^ 16'h5A5A, 1);
    rd(PER1_TOP, PER1_TOP[15:0] ^ 16'h5A5A, 1);
    rd(PER2_BASE, PER2_BASE[15:0] ^ 16'h5A5A, 1);
    chk(24'(m.flt), 24'h000000);
    rd(PER2_TOP, PER2_TOP[15:0] ^ 16'h5A5A, 1);
    rd(24'h003000, 16'h0000, 1);
    chk(24'(m.flt), 24'h000001);
    close_out();
  end
endmodule
